// ==== logic/chsf_status.sv ====
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
// Operation
// - response words read repeatedly or sequentially
// - command ready low while busy, cleared on command
// - receive ready set on data, cleared on read
// - transmit ready set when word reaches shifter
// - block ended on write, cleared on status read
// - dma mode: block ended only on last block
// - transfer in progress until crc16 done
// - not busy cleared at response, set on release
// - buffer end flags at zero count, cleared on write
// - buffer full/empty when both counters zero
// - index error set on mismatch, cleared on command
// - direction error set when bit missing
// - response crc error, cleared on command
// - end bit error, cleared on command
// - response timeout error, cleared on command
// - data crc error, cleared on status read
// - data timeout error, cleared on status read
// - overrun set on lost byte, cleared by start
// - underrun set on starved byte, cleared by start
// - slot interrupts, cleared on status read
// - enable register sets mask bits
// - disable register clears mask, mask readable
module chsf_status (
	input wire logic sys_clk,
	input wire logic rst,
	input wire chsf_pkg::chsf_bus_t bus,
	output logic [31:0] rdata,
	input wire chsf_pkg::chsf_evt_t evt,
	input wire logic [127:0] rsp_words,
	input wire logic [31:0] rx_word_data,
	output logic [31:0] tx_word,
	output logic cmd_write,
	output logic [31:0] cmd_value,
	input wire logic dat0_in,
	input wire logic slot_a_irq_in,
	input wire logic slot_b_irq_in,
	output logic irq
);
	import chsf_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [31:0] status_now;
	logic command_ready, receive_ready, transmit_ready, block_ended;
	logic transfer_in_progress, card_not_busy, receive_buffer_end, transmit_buffer_end;
	logic slot_a_card_irq, slot_b_card_irq, data_crc_error, data_timeout_error;
	logic receive_overrun, transmit_underrun;
	logic response_index_error, response_direction_error, response_crc_error;
	logic response_endbit_error, response_timeout_error;
	logic [31:0] mask;
	logic [31:0] rx_hold;
	logic [1:0] rsp_idx;
	logic dma_mode;
	logic [15:0] rcr, rncr, tcr, tncr;
	logic [2:0] dat0_sync, irqa_sync, irqb_sync;
	logic wait_busy;
	logic dec_rx_zero, dec_tx_zero;

	function automatic logic hit(input chsf_bus_t b, input logic [7:0] a, input logic w);
		hit = (b.addr == a) && (w ? b.wr : b.rd);
	endfunction : hit

	// counter decrement that reaches zero this cycle
	function automatic logic reach_zero(input logic [15:0] c, input logic dec);
		reach_zero = dec && (c == CNT_ONE);
	endfunction : reach_zero

	// one 32-bit word out of the four held for the card response
	function automatic logic [31:0] rsp_pick(input logic [127:0] w, input logic [1:0] k);
		rsp_pick = w[RSP_WORD_W * k +: RSP_WORD_W];
	endfunction : rsp_pick

	wire sr_rd = hit(bus, ADDR_SR, 1'b0);
	wire cmd_wr = hit(bus, ADDR_CMD, 1'b1);
	wire start_cmd = cmd_wr && (bus.wdata[CMD_TRCMD_LO +: 2] == TRCMD_START);
	wire rcnt_wr = hit(bus, ADDR_RCR, 1'b1) || hit(bus, ADDR_RNCR, 1'b1);
	wire tcnt_wr = hit(bus, ADDR_TCR, 1'b1) || hit(bus, ADDR_TNCR, 1'b1);
	wire both_tx_zero = (tcr == CNT_ZERO) && (tncr == CNT_ZERO);
	wire both_rx_zero = (rcr == CNT_ZERO) && (rncr == CNT_ZERO);
	assign dec_rx_zero = reach_zero(rcr, evt.dma_rx_dec);
	assign dec_tx_zero = reach_zero(tcr, evt.dma_tx_dec);

	// ---------------------------------------------------------------
	// input synchronisers: first stage read only by the second
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dat0_sync <= SYNC_HIGH;
			irqa_sync <= SYNC_LOW;
			irqb_sync <= SYNC_LOW;
		end else begin
			dat0_sync <= {dat0_sync[1:0], dat0_in};
			irqa_sync <= {irqa_sync[1:0], slot_a_irq_in};
			irqb_sync <= {irqb_sync[1:0], slot_b_irq_in};
		end
	end

	// edge detectors on the second and third stages
	wire dat0_rise = dat0_sync[1] && !dat0_sync[2];
	wire irqa_rise = irqa_sync[1] && !irqa_sync[2];
	wire irqb_rise = irqb_sync[1] && !irqb_sync[2];

	// ---------------------------------------------------------------
	// dma counters, loaded by software, decremented by the channel
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rcr <= CNT_ZERO;
			rncr <= CNT_ZERO;
			tcr <= CNT_ZERO;
			tncr <= CNT_ZERO;
		end else begin
			if (hit(bus, ADDR_RCR, 1'b1))
				rcr <= bus.wdata[15:0];
			else if (dec_rx_zero) begin
				rcr <= rncr; // next buffer moves in
			end else if (evt.dma_rx_dec && rcr != CNT_ZERO)
				rcr <= rcr - CNT_ONE;
			if (hit(bus, ADDR_RNCR, 1'b1))
				rncr <= bus.wdata[15:0];
			else if (dec_rx_zero)
				rncr <= CNT_ZERO;
			if (hit(bus, ADDR_TCR, 1'b1))
				tcr <= bus.wdata[15:0];
			else if (dec_tx_zero)
				tcr <= tncr;
			else if (evt.dma_tx_dec && tcr != CNT_ZERO)
				tcr <= tcr - CNT_ONE;
			if (hit(bus, ADDR_TNCR, 1'b1))
				tncr <= bus.wdata[15:0];
			else if (dec_tx_zero)
				tncr <= CNT_ZERO;
		end
	end

	// ---------------------------------------------------------------
	// mode, mask, data words
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst)
			dma_mode <= 1'b0;
		else if (hit(bus, ADDR_MODE, 1'b1))
			dma_mode <= bus.wdata[B_MODE_DMA];
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			mask <= WORD_ZERO;
		else if (hit(bus, ADDR_IER, 1'b1))
			mask <= mask | (bus.wdata & SR_IMPL_MASK);
		else if (hit(bus, ADDR_IDR, 1'b1))
			mask <= mask & ~bus.wdata;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_word <= WORD_ZERO;
			cmd_write <= 1'b0;
			cmd_value <= WORD_ZERO;
			rx_hold <= WORD_ZERO;
		end else begin
			cmd_write <= cmd_wr;
			if (cmd_wr)
				cmd_value <= bus.wdata;
			if (hit(bus, ADDR_TXD, 1'b1))
				tx_word <= bus.wdata;
			if (evt.rx_word)
				rx_hold <= rx_word_data;
		end
	end

	// response pointer: repeated reads at the first address walk the words
	always_ff @(posedge sys_clk) begin
		if (rst || cmd_wr)
			rsp_idx <= RSP_IDX_ZERO;
		else if (hit(bus, ADDR_RSP0, 1'b0))
			rsp_idx <= rsp_idx + 2'h1;
	end

	// not-busy tracking after every response end
	always_ff @(posedge sys_clk) begin
		if (rst)
			wait_busy <= 1'b0;
		else if (evt.rsp_end)
			wait_busy <= 1'b1;
		else if (dat0_rise)
			wait_busy <= 1'b0;
	end

	// ---------------------------------------------------------------
	// status flags: set wins over clear throughout
	// ---------------------------------------------------------------
	// command ready and the response errors, all cleared by a command write
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			command_ready <= 1'b1;
			response_index_error <= 1'b0;
			response_direction_error <= 1'b0;
			response_crc_error <= 1'b0;
			response_endbit_error <= 1'b0;
			response_timeout_error <= 1'b0;
		end else begin
			if (evt.cmd_sent)
				command_ready <= 1'b1;
			else if (cmd_wr)
				command_ready <= 1'b0;
			if (evt.rsp_index_bad)
				response_index_error <= 1'b1;
			else if (cmd_wr)
				response_index_error <= 1'b0;
			if (evt.rsp_dir_bad)
				response_direction_error <= 1'b1;
			else if (cmd_wr)
				response_direction_error <= 1'b0;
			if (evt.rsp_crc_bad)
				response_crc_error <= 1'b1;
			else if (cmd_wr)
				response_crc_error <= 1'b0;
			if (evt.rsp_end_bad)
				response_endbit_error <= 1'b1;
			else if (cmd_wr)
				response_endbit_error <= 1'b0;
			if (evt.rsp_timeout)
				response_timeout_error <= 1'b1;
			else if (cmd_wr)
				response_timeout_error <= 1'b0;
		end
	end

	// receive, transmit and block progress of the data path
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			receive_ready <= 1'b0;
			transmit_ready <= 1'b0;
			block_ended <= 1'b0;
			transfer_in_progress <= 1'b0;
		end else begin
			if (evt.rx_word)
				receive_ready <= 1'b1;
			else if (hit(bus, ADDR_RXD, 1'b0))
				receive_ready <= 1'b0;
			if (evt.tx_loaded)
				transmit_ready <= 1'b1;
			else if (hit(bus, ADDR_TXD, 1'b1))
				transmit_ready <= 1'b0;
			// in dma mode only the block that leaves both transmit counters empty counts
			if (evt.crc_status_end && (!dma_mode || both_tx_zero))
				block_ended <= 1'b1;
			else if (sr_rd)
				block_ended <= 1'b0;
			if (evt.xfer_start)
				transfer_in_progress <= 1'b1;
			else if (evt.crc16_done)
				transfer_in_progress <= 1'b0;
		end
	end

	// not busy: dropped at the response end, raised when the card lets data line 0 go
	always_ff @(posedge sys_clk) begin
		if (rst)
			card_not_busy <= 1'b1;
		else if (wait_busy && dat0_rise)
			card_not_busy <= 1'b1;
		else if (evt.rsp_end)
			card_not_busy <= 1'b0;
	end

	// buffer end flags follow the counters down to zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			receive_buffer_end <= 1'b0;
			transmit_buffer_end <= 1'b0;
		end else begin
			if (dec_rx_zero)
				receive_buffer_end <= 1'b1;
			else if (rcnt_wr)
				receive_buffer_end <= 1'b0;
			if (dec_tx_zero)
				transmit_buffer_end <= 1'b1;
			else if (tcnt_wr)
				transmit_buffer_end <= 1'b0;
		end
	end

	// card interrupts and data errors, all cleared by a status read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			slot_a_card_irq <= 1'b0;
			slot_b_card_irq <= 1'b0;
			data_crc_error <= 1'b0;
			data_timeout_error <= 1'b0;
		end else begin
			if (irqa_rise)
				slot_a_card_irq <= 1'b1;
			else if (sr_rd)
				slot_a_card_irq <= 1'b0;
			if (irqb_rise)
				slot_b_card_irq <= 1'b1;
			else if (sr_rd)
				slot_b_card_irq <= 1'b0;
			if (evt.data_crc_bad)
				data_crc_error <= 1'b1;
			else if (sr_rd)
				data_crc_error <= 1'b0;
			if (evt.data_timeout)
				data_timeout_error <= 1'b1;
			else if (sr_rd)
				data_timeout_error <= 1'b0;
		end
	end

	// lost and starved bytes, cleared only when a new transfer starts
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			receive_overrun <= 1'b0;
			transmit_underrun <= 1'b0;
		end else begin
			if (evt.rx_lost)
				receive_overrun <= 1'b1;
			else if (start_cmd)
				receive_overrun <= 1'b0;
			if (evt.tx_starved)
				transmit_underrun <= 1'b1;
			else if (start_cmd)
				transmit_underrun <= 1'b0;
		end
	end

	// status word; buffer full/empty follow the counters with no lag after a counter write
	always_comb begin
		status_now = WORD_ZERO;
		status_now[B_COMMAND_READY] = command_ready;
		status_now[B_RECEIVE_READY] = receive_ready;
		status_now[B_TRANSMIT_READY] = transmit_ready;
		status_now[B_BLOCK_ENDED] = block_ended;
		status_now[B_TRANSFER_IN_PROGRESS] = transfer_in_progress;
		status_now[B_NBUSY] = card_not_busy;
		status_now[B_RECEIVE_BUFFER_END] = receive_buffer_end;
		status_now[B_TRANSMIT_BUFFER_END] = transmit_buffer_end;
		status_now[B_IRQA] = slot_a_card_irq;
		status_now[B_IRQB] = slot_b_card_irq;
		status_now[B_RECEIVE_BUFFERS_FULL] = both_rx_zero;
		status_now[B_TRANSMIT_BUFFERS_EMPTY] = both_tx_zero;
		status_now[B_RESPONSE_INDEX_ERROR] = response_index_error;
		status_now[B_RESPONSE_DIRECTION_ERROR] = response_direction_error;
		status_now[B_RESPONSE_CRC_ERROR] = response_crc_error;
		status_now[B_RESPONSE_ENDBIT_ERROR] = response_endbit_error;
		status_now[B_RESPONSE_TIMEOUT_ERROR] = response_timeout_error;
		status_now[B_DATA_CRC_ERROR] = data_crc_error;
		status_now[B_DATA_TIMEOUT_ERROR] = data_timeout_error;
		status_now[B_RECEIVE_OVERRUN] = receive_overrun;
		status_now[B_TRANSMIT_UNDERRUN] = transmit_underrun;
	end

	// ---------------------------------------------------------------
	// interrupt output
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(status_now & mask);
	end

	// ---------------------------------------------------------------
	// read data, one cycle after the strobe
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst)
			rdata <= WORD_ZERO;
		else if (!bus.rd)
			rdata <= WORD_ZERO;
		else begin
			unique case (bus.addr)
				ADDR_RSP0: rdata <= rsp_pick(rsp_words, rsp_idx);
				ADDR_RSP1, ADDR_RSP2, ADDR_RSP3: rdata <= rsp_pick(rsp_words, bus.addr[RSP_SEL_LO +: 2]);
				ADDR_RXD: rdata <= rx_hold;
				ADDR_SR: rdata <= status_now;
				ADDR_IMR: rdata <= mask;
				ADDR_MODE: rdata <= {31'h0, dma_mode};
				ADDR_RCR: rdata <= {16'h0, rcr};
				ADDR_RNCR: rdata <= {16'h0, rncr};
				ADDR_TCR: rdata <= {16'h0, tcr};
				ADDR_TNCR: rdata <= {16'h0, tncr};
				default: rdata <= WORD_ZERO;
			endcase
		end
	end
endmodule : chsf_status

// ==== logic/chsf_pkg.sv ====
package chsf_pkg;
	// ---------------------------------------------------------------
	// register map, byte addresses on the plain port
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_RSP0 = 8'h20;
	localparam logic [7:0] ADDR_RSP1 = 8'h24;
	localparam logic [7:0] ADDR_RSP2 = 8'h28;
	localparam logic [7:0] ADDR_RSP3 = 8'h2c;
	localparam logic [7:0] ADDR_RXD = 8'h30;
	localparam logic [7:0] ADDR_TXD = 8'h34;
	localparam logic [7:0] ADDR_SR = 8'h40;
	localparam logic [7:0] ADDR_IER = 8'h44;
	localparam logic [7:0] ADDR_IDR = 8'h48;
	localparam logic [7:0] ADDR_IMR = 8'h4c;
	localparam logic [7:0] ADDR_MODE = 8'h50;
	localparam logic [7:0] ADDR_RCR = 8'h54;
	localparam logic [7:0] ADDR_RNCR = 8'h58;
	localparam logic [7:0] ADDR_TCR = 8'h5c;
	localparam logic [7:0] ADDR_TNCR = 8'h60;

	// ---------------------------------------------------------------
	// status bit positions
	// ---------------------------------------------------------------
	localparam int B_COMMAND_READY = 0;
	localparam int B_RECEIVE_READY = 1;
	localparam int B_TRANSMIT_READY = 2;
	localparam int B_BLOCK_ENDED = 3;
	localparam int B_TRANSFER_IN_PROGRESS = 4;
	localparam int B_NBUSY = 5;
	localparam int B_RECEIVE_BUFFER_END = 6;
	localparam int B_TRANSMIT_BUFFER_END = 7;
	localparam int B_IRQA = 8;
	localparam int B_IRQB = 9;
	localparam int B_RECEIVE_BUFFERS_FULL = 14;
	localparam int B_TRANSMIT_BUFFERS_EMPTY = 15;
	localparam int B_RESPONSE_INDEX_ERROR = 16;
	localparam int B_RESPONSE_DIRECTION_ERROR = 17;
	localparam int B_RESPONSE_CRC_ERROR = 18;
	localparam int B_RESPONSE_ENDBIT_ERROR = 19;
	localparam int B_RESPONSE_TIMEOUT_ERROR = 20;
	localparam int B_DATA_CRC_ERROR = 21;
	localparam int B_DATA_TIMEOUT_ERROR = 22;
	localparam int B_RECEIVE_OVERRUN = 30;
	localparam int B_TRANSMIT_UNDERRUN = 31;
	localparam logic [31:0] SR_IMPL_MASK = 32'hc07f_c3ff;
	localparam int B_MODE_DMA = 0;
	localparam int CMD_TRCMD_LO = 16;
	localparam logic [1:0] TRCMD_START = 2'h1;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [1:0] RSP_IDX_ZERO = 2'h0;
	localparam int RSP_WORD_W = 32;
	localparam int RSP_SEL_LO = 2;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [2:0] SYNC_HIGH = 3'h7;
	localparam logic [2:0] SYNC_LOW = 3'h0;

	// ---------------------------------------------------------------
	// register port and engine event carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} chsf_bus_t;

	typedef struct packed {
		logic cmd_sent;
		logic rsp_end;
		logic rsp_index_bad;
		logic rsp_dir_bad;
		logic rsp_crc_bad;
		logic rsp_end_bad;
		logic rsp_timeout;
		logic rx_word;
		logic tx_loaded;
		logic crc_status_end;
		logic xfer_start;
		logic crc16_done;
		logic data_crc_bad;
		logic data_timeout;
		logic rx_lost;
		logic tx_starved;
		logic dma_rx_dec;
		logic dma_tx_dec;
	} chsf_evt_t;
endpackage : chsf_pkg

// ==== tb/chsf_status_checker.sv ====
`timescale 1ns/100ps
module chsf_status_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire chsf_pkg::chsf_bus_t bus,
	input wire logic [31:0] rdata,
	input wire chsf_pkg::chsf_evt_t evt,
	input wire logic [127:0] rsp_words,
	input wire logic [31:0] rx_word_data,
	input wire logic [31:0] tx_word,
	input wire logic cmd_write,
	input wire logic [31:0] cmd_value,
	input wire logic dat0_in,
	input wire logic slot_a_irq_in,
	input wire logic slot_b_irq_in,
	input wire logic irq
);
	import chsf_pkg::*;
	// ---------------------------------------------------------------
	// access decode and properties
	// ---------------------------------------------------------------
	// strobes qualified by address
	wire logic sr_rd = bus.rd && bus.addr == ADDR_SR;
	wire logic rx_rd = bus.rd && bus.addr == ADDR_RXD;
	wire logic cmd_wr = bus.wr && bus.addr == ADDR_CMD;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_CMD_PULSE: assert property (cmd_wr |=> cmd_write && cmd_value == $past(bus.wdata))
		else $error("command write not passed on");
	AST_TX_WORD: assert property (bus.wr && bus.addr == ADDR_TXD |=> tx_word == $past(bus.wdata))
		else $error("transmit word not taken");
	AST_RSP_FIRST: assert property (cmd_wr ##1 bus.rd && bus.addr == ADDR_RSP0 |=> rdata == $past(rsp_words[31:0]))
		else $error("first response word wrong");
	AST_COMMAND_READY_LOW: assert property (cmd_wr && !evt.cmd_sent ##1 sr_rd |=> !rdata[B_COMMAND_READY])
		else $error("command ready not cleared");
	AST_RECEIVE_READY_CLR: assert property (rx_rd && !evt.rx_word ##1 sr_rd |=> !rdata[B_RECEIVE_READY])
		else $error("receive ready not cleared");
	AST_RX_DATA: assert property (evt.rx_word ##1 rx_rd && !evt.rx_word |=> rdata == $past(rx_word_data, 2))
		else $error("receive word wrong");
	AST_DATA_CRC_ERROR_CLR: assert property (sr_rd && !evt.data_crc_bad ##1 sr_rd |=> !rdata[B_DATA_CRC_ERROR])
		else $error("data crc error not cleared");
	AST_DATA_TIMEOUT_ERROR_CLR: assert property (sr_rd && !evt.data_timeout ##1 sr_rd |=> !rdata[B_DATA_TIMEOUT_ERROR])
		else $error("data timeout not cleared");
	AST_RECEIVE_OVERRUN_SET: assert property (evt.rx_lost ##1 sr_rd |=> rdata[B_RECEIVE_OVERRUN])
		else $error("overrun not reported");
	AST_IRQ_OFF: assert property (bus.wr && bus.addr == ADDR_IDR && bus.wdata == '1 ##1
		!(bus.wr && bus.addr == ADDR_IER) |=> !irq) else $error("request with all disabled");
endmodule : chsf_status_checker

bind chsf_status chsf_status_checker u_chsf_status_checker (.sys_clk(sys_clk), .rst(rst), .bus(bus),
	.rdata(rdata), .evt(evt), .rsp_words(rsp_words), .rx_word_data(rx_word_data), .tx_word(tx_word),
	.cmd_write(cmd_write), .cmd_value(cmd_value), .dat0_in(dat0_in), .slot_a_irq_in(slot_a_irq_in),
	.slot_b_irq_in(slot_b_irq_in), .irq(irq));

// ==== tb/chsf_card_model.sv ====
`timescale 1ns/100ps
module chsf_card_model #(
	parameter int BUSY_CYCLES = 12
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic busy_go,
	output logic dat0
);
	// ---------------------------------------------------------------
	// busy signalling on data line 0
	// ---------------------------------------------------------------
	logic [7:0] busy_cnt;
	// count the time the card has no free receive buffer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busy_cnt <= 8'h00;
		end else if (busy_go) begin
			busy_cnt <= 8'(BUSY_CYCLES);
		end else if (busy_cnt != 8'h00) begin
			busy_cnt <= busy_cnt - 8'h01;
		end
	end
	// low while busy, pulled up once a buffer is free
	assign dat0 = (busy_cnt == 8'h00);
endmodule : chsf_card_model

// ==== tb/chsf_status_tb_top.sv ====
`timescale 1ns/100ps
module chsf_status_tb_top;
	import chsf_pkg::*;
	// ---------------------------------------------------------------
	// stimulus state and instances
	// ---------------------------------------------------------------
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	chsf_bus_t bus = '0;
	chsf_evt_t evt = '0;
	logic [127:0] rsp_words = 128'h3333_0303_2222_0202_1111_0101_0000_0f0f;
	logic slot_a = 1'b0;
	logic slot_b = 1'b0;
	logic busy_go = 1'b0;
	logic dat0;
	logic irq;
	logic [31:0] rdata;
	logic [31:0] tx_word;
	logic cmd_write;
	logic [31:0] cmd_value;
	int n_errors = 0;
	int total_checks = 0;
	int i;
	chsf_status u_chsf_status (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .evt(evt),
		.rsp_words(rsp_words), .rx_word_data(32'hcafe_0123), .tx_word(tx_word), .cmd_write(cmd_write),
		.cmd_value(cmd_value), .dat0_in(dat0), .slot_a_irq_in(slot_a), .slot_b_irq_in(slot_b), .irq(irq));
	chsf_card_model u_chsf_card_model (.sys_clk(sys_clk), .rst(rst), .busy_go(busy_go), .dat0(dat0));
	// 25 MHz clock
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	// ---------------------------------------------------------------
	// access tasks
	// ---------------------------------------------------------------
	// compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one-cycle register write
	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
		#1;
	endtask : bw
	// register read, masked data checked in the cycle after the strobe
	task automatic br(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata & m, e);
	endtask : br
	// status bit read
	task automatic sb(input int b, input logic v);
		br(ADDR_SR, 32'h1 << b, 32'(v) << b);
	endtask : sb
	// one-cycle engine event, k counts event bits from the lsb
	task automatic ev(input int k);
		evt <= chsf_evt_t'(18'h1 << k);
		@(posedge sys_clk);
		evt <= '0;
		#1;
	endtask : ev
	// counts and verdict
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		br(ADDR_SR, 32'hc07f_c33b, 32'h0000_c021);
		bw(ADDR_CMD, 32'h0);
		for (i = 0; i < 8; i++) begin
			br(ADDR_RSP0, '1, rsp_words[32 * (i % 4) +: 32]);
		end
		sb(B_COMMAND_READY, 1'b0);
		ev(17);
		sb(B_COMMAND_READY, 1'b1);
		bw(ADDR_CMD, 32'h0);
		for (i = 0; i < 4; i++) begin
			br(ADDR_RSP0 + 8'(4 * i), '1, rsp_words[32 * i +: 32]);
		end
		for (i = 0; i < 5; i++) begin
			ev(15 - i);
			sb(16 + i, 1'b1);
			bw(ADDR_CMD, 32'h0);
			sb(16 + i, 1'b0);
		end
		for (i = 0; i < 2; i++) begin
			ev(5 - i);
			{slot_b, slot_a} <= 2'(i + 1);
			repeat (5) @(posedge sys_clk);
			#1;
			br(ADDR_SR, (32'h1 << (21 + i)) | (32'h1 << (8 + i)), (32'h1 << (21 + i)) | (32'h1 << (8 + i)));
			br(ADDR_SR, (32'h1 << (21 + i)) | (32'h1 << (8 + i)), 32'h0);
		end
		ev(2);
		ev(3);
		br(ADDR_SR, 32'hc000_0000, 32'hc000_0000);
		bw(ADDR_CMD, 32'h0);
		br(ADDR_SR, 32'hc000_0000, 32'hc000_0000);
		bw(ADDR_CMD, 32'h0001_0000);
		chk(cmd_write, 32'h1);
		chk(cmd_value, 32'h0001_0000);
		br(ADDR_SR, 32'hc000_0000, 32'h0);
		ev(10);
		br(ADDR_RXD, '1, 32'hcafe_0123);
		sb(B_RECEIVE_READY, 1'b0);
		ev(10);
		sb(B_RECEIVE_READY, 1'b1);
		bw(ADDR_TXD, 32'h5a5a_0f0f);
		chk(tx_word, 32'h5a5a_0f0f);
		sb(B_TRANSMIT_READY, 1'b0);
		ev(9);
		sb(B_TRANSMIT_READY, 1'b1);
		ev(7);
		sb(B_TRANSFER_IN_PROGRESS, 1'b1);
		ev(6);
		sb(B_TRANSFER_IN_PROGRESS, 1'b0);
		busy_go <= 1'b1;
		ev(16);
		busy_go <= 1'b0;
		sb(B_NBUSY, 1'b0);
		repeat (30) @(posedge sys_clk);
		#1;
		sb(B_NBUSY, 1'b1);
		ev(8);
		sb(B_BLOCK_ENDED, 1'b1);
		sb(B_BLOCK_ENDED, 1'b0);
		bw(ADDR_MODE, 32'h1);
		bw(ADDR_TCR, 32'h2);
		bw(ADDR_RCR, 32'h1);
		br(ADDR_SR, 32'h0000_c0c0, 32'h0);
		ev(8);
		sb(B_BLOCK_ENDED, 1'b0);
		ev(0);
		ev(0);
		ev(1);
		br(ADDR_SR, 32'h0000_c0c0, 32'h0000_c0c0);
		ev(8);
		sb(B_BLOCK_ENDED, 1'b1);
		bw(ADDR_TNCR, 32'h0);
		br(ADDR_SR, 32'h0000_c0c0, 32'h0000_c040);
		bw(ADDR_IDR, 32'hffff_ffff);
		bw(ADDR_IER, 32'h4000_0000);
		bw(ADDR_IER, 32'h0);
		br(ADDR_IMR, '1, 32'h4000_0000);
		ev(3);
		repeat (2) @(posedge sys_clk);
		#1;
		chk(irq, 32'h1);
		bw(ADDR_IDR, 32'hffff_ffff);
		br(ADDR_IMR, '1, 32'h0);
		chk(irq, 32'h0);
		br(8'h7c, '1, 32'h0);
		give_verdict();
	end
endmodule : chsf_status_tb_top
